// >>> hdl/bsc_tap_regs.svh
// constants of the boundary-scan test access port
`ifndef BSC_TAP_REGS_SVH
`define BSC_TAP_REGS_SVH

`define BSC_IR_W          4
`define BSC_IR_BYPASS     4'h0
`define BSC_IR_PRELOAD    4'h1
`define BSC_IR_SAMPLE     4'h2
`define BSC_IR_IDCODE     4'h3
`define BSC_IR_USERCODE   4'h4
`define BSC_IR_CLAMP      4'h5
`define BSC_IR_HIGHZ      4'h6
`define BSC_IR_EXTEST     4'h7
`define BSC_IR_IFCTL      4'h8
`define BSC_IR_REGRD      4'h9
`define BSC_IR_REGWR      4'ha
`define BSC_IR_CAPTURE    4'h1

`define BSC_PINS          12
`define BSC_BSR_LEN       24
`define BSC_ID_LEN        32
`define BSC_REG_LEN       15
`define BSC_ADDR_W        7
`define BSC_DATA_W        8
`define BSC_DR_W          32
`define BSC_DR_LEN_W      6

`define BSC_LEN_BYPASS    6'h01
`define BSC_LEN_BSR       6'h18
`define BSC_LEN_ID        6'h20
`define BSC_LEN_REG       6'h0f

`endif

// >>> hdl/bsc_pkg.sv
// types of the boundary-scan test access port
package bsc_pkg;

    typedef enum logic [3:0] {
        st_reset   = 4'h0,
        st_idle    = 4'h1,
        st_sel_dr  = 4'h3,
        st_cap_dr  = 4'h2,
        st_sh_dr   = 4'h6,
        st_ex1_dr  = 4'h7,
        st_pau_dr  = 4'h5,
        st_ex2_dr  = 4'h4,
        st_upd_dr  = 4'hc,
        st_sel_ir  = 4'hd,
        st_cap_ir  = 4'hf,
        st_sh_ir   = 4'he,
        st_ex1_ir  = 4'ha,
        st_pau_ir  = 4'hb,
        st_ex2_ir  = 4'h9,
        st_upd_ir  = 4'h8
    } bsc_state_t;

    typedef struct packed {
        logic [3:0]  ir_sh;
        logic [3:0]  ir;
        logic [31:0] dr_sh;
        logic [23:0] bsr_upd;
        logic [6:0]  cur_addr;
        logic        if_off;
        logic        mode_drv;
        logic        mode_hiz;
        logic        wr_tgl;
        logic [6:0]  wr_addr;
        logic [7:0]  wr_data;
    } bsc_tck_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } bsc_out_t;

    typedef struct packed {
        logic [11:0] pad_out;
        logic [11:0] pad_oe;
        logic        host_if_off;
        logic        wr_seen;
        logic        wr_pulse;
        logic [6:0]  wr_addr;
        logic [7:0]  wr_data;
        logic [6:0]  rd_addr;
        logic [7:0]  rd_hold;
    } bsc_sys_t;

endpackage

// >>> hdl/bsc_sync.sv
// two flip-flop synchroniser for a bundle of quasi-static levels
`timescale 1ns/1ps
`default_nettype none

module bsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    // the first stage feeds only the second
    always_comb begin
        meta_next = d;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign q = sync_reg;

endmodule // bsc_sync

`default_nettype wire

// >>> hdl/bsc_tap_fsm.sv
// sixteen-state test access port controller
`timescale 1ns/1ps
`default_nettype none

module bsc_tap_fsm (
    input  wire logic               tck,
    input  wire logic               rst_tck,
    input  wire logic               tms,
    output bsc_pkg::bsc_state_t     state
);

    bsc_pkg::bsc_state_t state_reg;
    bsc_pkg::bsc_state_t state_next;

    // next state from current state and tms sampled at the rising edge
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            bsc_pkg::st_reset:  state_next = tms ? bsc_pkg::st_reset  : bsc_pkg::st_idle;
            bsc_pkg::st_idle:   state_next = tms ? bsc_pkg::st_sel_dr : bsc_pkg::st_idle;
            bsc_pkg::st_sel_dr: state_next = tms ? bsc_pkg::st_sel_ir : bsc_pkg::st_cap_dr;
            bsc_pkg::st_cap_dr: state_next = tms ? bsc_pkg::st_ex1_dr : bsc_pkg::st_sh_dr;
            bsc_pkg::st_sh_dr:  state_next = tms ? bsc_pkg::st_ex1_dr : bsc_pkg::st_sh_dr;
            bsc_pkg::st_ex1_dr: state_next = tms ? bsc_pkg::st_upd_dr : bsc_pkg::st_pau_dr;
            bsc_pkg::st_pau_dr: state_next = tms ? bsc_pkg::st_ex2_dr : bsc_pkg::st_pau_dr;
            bsc_pkg::st_ex2_dr: state_next = tms ? bsc_pkg::st_upd_dr : bsc_pkg::st_sh_dr;
            bsc_pkg::st_upd_dr: state_next = tms ? bsc_pkg::st_sel_dr : bsc_pkg::st_idle;
            bsc_pkg::st_sel_ir: state_next = tms ? bsc_pkg::st_reset  : bsc_pkg::st_cap_ir;
            bsc_pkg::st_cap_ir: state_next = tms ? bsc_pkg::st_ex1_ir : bsc_pkg::st_sh_ir;
            bsc_pkg::st_sh_ir:  state_next = tms ? bsc_pkg::st_ex1_ir : bsc_pkg::st_sh_ir;
            bsc_pkg::st_ex1_ir: state_next = tms ? bsc_pkg::st_upd_ir : bsc_pkg::st_pau_ir;
            bsc_pkg::st_pau_ir: state_next = tms ? bsc_pkg::st_ex2_ir : bsc_pkg::st_pau_ir;
            bsc_pkg::st_ex2_ir: state_next = tms ? bsc_pkg::st_upd_ir : bsc_pkg::st_sh_ir;
            bsc_pkg::st_upd_ir: state_next = tms ? bsc_pkg::st_sel_dr : bsc_pkg::st_idle;
            default:            state_next = bsc_pkg::st_reset;
        endcase
    end

    // only tck moves the state, so a stopped tck freezes it
    always_ff @(posedge tck) begin
        if (rst_tck) begin
            state_reg <= bsc_pkg::st_reset;
        end else begin
            state_reg <= state_next;
        end
    end

    assign state = state_reg;

endmodule // bsc_tap_fsm

`default_nettype wire

// >>> hdl/bsc_tap.sv
// boundary-scan test access port with boundary cells and register access
//
// How it works
// - codes 0,1,2,5,6,7 standard; 24-bit boundary image
// - code 3 idcode default, code 4 usercode
// - codes 8,9,10: interface, register read, write
// - four test pins: tck, tms, tdi, tdo
// - shared tck/tms, tdi-to-tdo scan path
// - test logic runs on tck; pad override and register access on ref_clk
// - stopped tck keeps state and registers
// - pulled-up inputs idle high, no clocking
// - tms sampled on rising tck edge
// - five tms-high clocks reach test-logic-reset
// - test-logic-reset loads the idcode instruction
// - tdi shifted into selected chain on rise
// - boundary cells override every device pin
// - tdo changes on fall, released when idle
// - interface-off bit taken at update-dr
// - read: capture address, update new address
// - write: capture-dr writes data at address
`timescale 1ns/1ps
`default_nettype none

`include "bsc_tap_regs.svh"

module bsc_tap #(
    parameter logic [31:0] ID_CODE   = 32'h1000_1001, // arbitrary value
    parameter logic [31:0] USER_CODE = 32'h0000_0001  // arbitrary value
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    output logic             tdo,
    output logic             tdo_oe,
    input  wire logic [11:0] core_out,
    input  wire logic [11:0] core_oe,
    input  wire logic [11:0] pad_in,
    output logic      [11:0] pad_out,
    output logic      [11:0] pad_oe,
    output logic             host_if_off,
    output logic             reg_wr_pulse,
    output logic      [6:0]  reg_wr_addr,
    output logic      [7:0]  reg_wr_data,
    output logic      [6:0]  reg_rd_addr,
    input  wire logic [7:0]  reg_rd_data
);

    ////////////////////////////////////////////////////////////////////////
    // crossings

    logic                rst_tck;
    logic [31:0]         to_tck_d;
    logic [31:0]         to_tck_q;
    logic [49:0]         to_sys_d;
    logic [49:0]         to_sys_q;
    logic [11:0]         pin_s;
    logic [11:0]         ctl_s;
    logic [7:0]          rd_s;
    bsc_pkg::bsc_state_t state;
    bsc_pkg::bsc_tck_t   t_reg;
    bsc_pkg::bsc_tck_t   t_next;
    bsc_pkg::bsc_out_t   o_reg;
    bsc_pkg::bsc_out_t   o_next;
    bsc_pkg::bsc_sys_t   s_reg;
    bsc_pkg::bsc_sys_t   s_next;

    bsc_sync #(.W(1)) u_rst_sync (
        .clk (tck),
        .d   (rst),
        .q   (rst_tck)
    );

    assign to_tck_d = {s_reg.rd_hold, core_oe, pad_in};

    bsc_sync #(.W(32)) u_to_tck (
        .clk (tck),
        .d   (to_tck_d),
        .q   (to_tck_q)
    );

    assign pin_s = to_tck_q[11:0];
    assign ctl_s = to_tck_q[23:12];
    assign rd_s  = to_tck_q[31:24];

    assign to_sys_d = {t_reg.if_off, t_reg.wr_tgl, t_reg.wr_addr, t_reg.wr_data,
                       t_reg.cur_addr, t_reg.mode_drv, t_reg.mode_hiz, t_reg.bsr_upd};

    bsc_sync #(.W(50)) u_to_sys (
        .clk (ref_clk),
        .d   (to_sys_d),
        .q   (to_sys_q)
    );

    bsc_tap_fsm u_fsm (
        .tck     (tck),
        .rst_tck (rst_tck),
        .tms     (tms),
        .state   (state)
    );

    ////////////////////////////////////////////////////////////////////////
    // test clock domain

    // length of the chain the active instruction puts between tdi and tdo
    function automatic logic [5:0] dr_len(input logic [3:0] ir, input logic off);
        logic [5:0] len;
        len = `BSC_LEN_BYPASS;
        case (ir)
            `BSC_IR_PRELOAD,
            `BSC_IR_SAMPLE,
            `BSC_IR_EXTEST:   len = `BSC_LEN_BSR;
            `BSC_IR_IDCODE,
            `BSC_IR_USERCODE: len = `BSC_LEN_ID;
            `BSC_IR_REGRD,
            `BSC_IR_REGWR:    len = off ? `BSC_LEN_REG : `BSC_LEN_BYPASS;
            default:          len = `BSC_LEN_BYPASS;
        endcase
        return len;
    endfunction

    logic [5:0]  len;
    logic [31:0] bsr_cap;
    logic        reg_ok;

    assign len    = dr_len(t_reg.ir, t_reg.if_off);
    assign reg_ok = t_reg.if_off;

    // capture image: control cell odd, data cell even, pin 0 lowest
    genvar g;
    generate
        for (g = 0; g < `BSC_PINS; g++) begin : g_cell
            assign bsr_cap[2*g]   = pin_s[g];
            assign bsr_cap[2*g+1] = ctl_s[g];
        end
    endgenerate
    assign bsr_cap[31:24] = 8'h00;

    always_comb begin
        t_next = t_reg;
        case (state)
            bsc_pkg::st_reset: begin
                t_next.ir       = `BSC_IR_IDCODE;
                t_next.mode_drv = 1'b0;
                t_next.mode_hiz = 1'b0;
                t_next.if_off   = 1'b0;
            end
            bsc_pkg::st_cap_ir: begin
                t_next.ir_sh = `BSC_IR_CAPTURE;
            end
            bsc_pkg::st_sh_ir: begin
                t_next.ir_sh = {tdi, t_reg.ir_sh[3:1]};
            end
            bsc_pkg::st_upd_ir: begin
                t_next.ir       = t_reg.ir_sh;
                t_next.mode_drv = (t_reg.ir_sh == `BSC_IR_EXTEST) ||
                                  (t_reg.ir_sh == `BSC_IR_CLAMP);
                t_next.mode_hiz = (t_reg.ir_sh == `BSC_IR_HIGHZ);
            end
            bsc_pkg::st_cap_dr: begin
                case (t_reg.ir)
                    `BSC_IR_PRELOAD,
                    `BSC_IR_SAMPLE,
                    `BSC_IR_EXTEST:   t_next.dr_sh = bsr_cap;
                    `BSC_IR_IDCODE:   t_next.dr_sh = ID_CODE;
                    `BSC_IR_USERCODE: t_next.dr_sh = USER_CODE;
                    `BSC_IR_IFCTL:    t_next.dr_sh = {31'h0000_0000, t_reg.if_off};
                    `BSC_IR_REGRD: begin
                        if (reg_ok) begin
                            t_next.dr_sh = {17'h0_0000, rd_s, t_reg.cur_addr};
                        end else begin
                            t_next.dr_sh = 32'h0000_0000;
                        end
                    end
                    `BSC_IR_REGWR: begin
                        if (reg_ok) begin
                            t_next.wr_addr = t_reg.dr_sh[6:0];
                            t_next.wr_data = t_reg.dr_sh[14:7];
                            t_next.wr_tgl  = ~t_reg.wr_tgl;
                        end else begin
                            t_next.dr_sh = 32'h0000_0000;
                        end
                    end
                    default:          t_next.dr_sh = 32'h0000_0000;
                endcase
            end
            bsc_pkg::st_sh_dr: begin
                for (int i = 0; i < `BSC_DR_W; i++) begin
                    if (i == int'(len) - 1) begin
                        t_next.dr_sh[i] = tdi;
                    end else if (i < int'(len) - 1) begin
                        t_next.dr_sh[i] = t_reg.dr_sh[i+1];
                    end else begin
                        t_next.dr_sh[i] = 1'b0;
                    end
                end
            end
            bsc_pkg::st_upd_dr: begin
                case (t_reg.ir)
                    `BSC_IR_PRELOAD,
                    `BSC_IR_EXTEST: t_next.bsr_upd = t_reg.dr_sh[23:0];
                    `BSC_IR_IFCTL:  t_next.if_off  = t_reg.dr_sh[0];
                    `BSC_IR_REGRD: begin
                        if (reg_ok) begin
                            t_next.cur_addr = t_reg.dr_sh[6:0];
                        end
                    end
                    default: t_next.if_off = t_reg.if_off;
                endcase
            end
            default: t_next.ir = t_reg.ir;
        endcase
    end

    always_ff @(posedge tck) begin
        if (rst_tck) begin
            t_reg         <= '0;
            t_reg.ir      <= `BSC_IR_IDCODE;
        end else begin
            t_reg <= t_next;
        end
    end

    // tdo is driven only while a chain is being shifted
    always_comb begin
        o_next.tdo    = 1'b0;
        o_next.tdo_oe = 1'b0;
        if (state == bsc_pkg::st_sh_dr) begin
            o_next.tdo    = t_reg.dr_sh[0];
            o_next.tdo_oe = 1'b1;
        end else if (state == bsc_pkg::st_sh_ir) begin
            o_next.tdo    = t_reg.ir_sh[0];
            o_next.tdo_oe = 1'b1;
        end
    end

    always_ff @(negedge tck) begin
        if (rst_tck) begin
            o_reg <= '0;
        end else begin
            o_reg <= o_next;
        end
    end

    assign tdo    = o_reg.tdo;
    assign tdo_oe = o_reg.tdo_oe;

    ////////////////////////////////////////////////////////////////////////
    // system clock domain: pad override and register access

    logic [23:0] upd_s;
    logic        hiz_s;
    logic        drv_s;
    logic [6:0]  cur_s;
    logic [7:0]  wdat_s;
    logic [6:0]  wadr_s;
    logic        tgl_s;
    logic        off_s;

    assign upd_s  = to_sys_q[23:0];
    assign hiz_s  = to_sys_q[24];
    assign drv_s  = to_sys_q[25];
    assign cur_s  = to_sys_q[32:26];
    assign wdat_s = to_sys_q[40:33];
    assign wadr_s = to_sys_q[47:41];
    assign tgl_s  = to_sys_q[48];
    assign off_s  = to_sys_q[49];

    always_comb begin
        s_next          = s_reg;
        s_next.wr_seen  = tgl_s;
        s_next.wr_pulse = tgl_s ^ s_reg.wr_seen;
        if (tgl_s ^ s_reg.wr_seen) begin
            s_next.wr_addr = wadr_s;
            s_next.wr_data = wdat_s;
        end
        s_next.host_if_off = off_s;
        s_next.rd_addr     = cur_s;
        s_next.rd_hold     = reg_rd_data;
        for (int k = 0; k < `BSC_PINS; k++) begin
            if (hiz_s) begin
                s_next.pad_out[k] = 1'b0;
                s_next.pad_oe[k]  = 1'b0;
            end else if (drv_s) begin
                s_next.pad_out[k] = upd_s[2*k];
                s_next.pad_oe[k]  = upd_s[2*k+1];
            end else begin
                s_next.pad_out[k] = core_out[k];
                s_next.pad_oe[k]  = core_oe[k];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pad_out      = s_reg.pad_out;
    assign pad_oe       = s_reg.pad_oe;
    assign host_if_off  = s_reg.host_if_off;
    assign reg_wr_pulse = s_reg.wr_pulse;
    assign reg_wr_addr  = s_reg.wr_addr;
    assign reg_wr_data  = s_reg.wr_data;
    assign reg_rd_addr  = s_reg.rd_addr;

endmodule // bsc_tap

`default_nettype wire

// >>> sim/bsc_tap_chk.sv
// port assertions of the boundary-scan test access port
`timescale 1ns/1ps
`default_nettype none

module bsc_tap_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        tck,
    input wire logic        tms,
    input wire logic        tdo,
    input wire logic        tdo_oe,
    input wire logic [11:0] pad_out,
    input wire logic [11:0] pad_oe,
    input wire logic        host_if_off,
    input wire logic        reg_wr_pulse,
    input wire logic [6:0]  reg_wr_addr,
    input wire logic [7:0]  reg_wr_data,
    input wire logic [6:0]  reg_rd_addr
);
    sequence five_high_s;
        tms [*5];
    endsequence

    sequence no_shift_s;
        !tdo_oe [*4];
    endsequence

    tdo_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        $stable(tck) |-> $stable({tdo, tdo_oe}))
        else $error("tdo moved while tck stood still");
    oe_follow_a: assert property (@(negedge tck) disable iff (rst)
        tdo_oe |=> tdo_oe == !$past(tms))
        else $error("tdo enable does not follow shift state");
    oe_entry_a: assert property (@(negedge tck) disable iff (rst)
        $rose(tdo_oe) |-> !$past(tms))
        else $error("shift entered with tms high");
    five_high_a: assert property (@(negedge tck) disable iff (rst)
        five_high_s |=> no_shift_s)
        else $error("shift reached too soon after five tms highs");
    wr_single_a: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr_pulse |=> !reg_wr_pulse)
        else $error("write pulse longer than one cycle");
    wr_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        $changed({reg_wr_addr, reg_wr_data}) |-> reg_wr_pulse)
        else $error("write address or data moved without pulse");
    wr_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
        reg_wr_pulse |-> host_if_off)
        else $error("write while host interface active");
    rd_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(reg_rd_addr) |-> host_if_off || $past(host_if_off, 4))
        else $error("read address moved while host interface active");
    reset_quiet_a: assert property (@(posedge ref_clk)
        rst |=> {pad_out, pad_oe, host_if_off, reg_wr_pulse} == 26'h0)
        else $error("outputs not cleared by reset");
endmodule // bsc_tap_chk

bind bsc_tap bsc_tap_chk chk (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
    .pad_out(pad_out), .pad_oe(pad_oe), .host_if_off(host_if_off), .reg_wr_pulse(reg_wr_pulse),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr));

`default_nettype wire

// >>> sim/bsc_jtag_host.sv
// test controller model driving the boundary-scan pins
`timescale 1ns/1ps
`default_nettype none

module bsc_jtag_host (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    bit   stall;
    logic s_tdo;
    logic s_oe;
    logic oe_ok;

    // pulled-up pins read high until driven; tck stands high outside frames
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
        stall = 1'b0;
    end

    // one tck period: tms and tdi move after the fall, tdo taken at the rise
    task automatic step(input logic m, input logic d);
        tck = 1'b0;
        #1;
        tms = m;
        tdi = d;
        if (stall) #2000;
        #61.5;
        s_tdo = tdo;
        s_oe = tdo_oe;
        tck = 1'b1;
        #62.5;
    endtask

    // full scan from idle back to idle, lsb first
    task automatic scan(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = 32'h0;
        oe_ok = 1'b1;
        step(1'b1, 1'b1);
        if (ir) step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            dout[i] = s_tdo;
            oe_ok = oe_ok & s_oe;
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask

    task automatic tlr(input int n);
        repeat (n) step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
endmodule // bsc_jtag_host

`default_nettype wire

// >>> sim/bsc_tap_tb_top.sv
// self-checking bench of the boundary-scan test access port
`timescale 1ns/1ps
`default_nettype none

`include "bsc_tap_regs.svh"

module bsc_tap_tb_top;
    localparam logic [31:0] TB_ID   = 32'h5a3c_0e71; // arbitrary value
    localparam logic [31:0] TB_USER = 32'h00c3_9a01; // arbitrary value
    localparam logic [31:0] PAT     = 32'h9e37_79b5;

    typedef struct packed {
        logic [3:0]  code;
        logic [5:0]  len;
        logic [31:0] cap;
    } bsc_row_t;

    logic        ref_clk, rst, tck, tms, tdi, tdo, tdo_oe, host_if_off, reg_wr_pulse;
    logic [11:0] core_out, core_oe, pad_in, pad_out, pad_oe;
    logic [6:0]  reg_wr_addr, reg_rd_addr, wr_a;
    logic [7:0]  reg_wr_data, reg_rd_data, wr_d;
    logic [7:0]  regs_mem [128];
    int          wr_cnt = 0;
    int          mismatches = 0;
    int          check_count = 0;
    bsc_row_t    rows [11];

    bsc_tap #(.ID_CODE(TB_ID), .USER_CODE(TB_USER)) dut (
        .ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .core_out(core_out), .core_oe(core_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .host_if_off(host_if_off), .reg_wr_pulse(reg_wr_pulse), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data));
    bsc_jtag_host ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    // internal register file reached through the vendor instructions
    assign reg_rd_data = regs_mem[reg_rd_addr];
    always @(posedge ref_clk) if (reg_wr_pulse) begin
        regs_mem[reg_wr_addr] <= reg_wr_data;
        wr_a <= reg_wr_addr;
        wr_d <= reg_wr_data;
        wr_cnt <= wr_cnt + 1;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial begin
        #300000;
        mismatches++;
        conclude();
    end

    initial begin
        logic [31:0] got;
        logic [63:0] want;
        logic [23:0] bsr;
        logic [11:0] po, pe, uo, ue;
        int          n0;
        rst = 1'b1;
        core_out = 12'h93e;
        core_oe = 12'h3c6;
        pad_in = 12'ha5c;
        for (int i = 0; i < 128; i++) regs_mem[i] = 8'h6d ^ 8'(i);
        for (int k = 0; k < 12; k++) begin
            bsr[2*k] = pad_in[k];
            bsr[2*k+1] = core_oe[k];
            uo[k] = PAT[8+2*k];
            ue[k] = PAT[9+2*k];
        end
        rows = '{
            '{`BSC_IR_BYPASS,   6'h01, 32'h0},
            '{`BSC_IR_PRELOAD,  6'h18, 32'(bsr)},
            '{`BSC_IR_SAMPLE,   6'h18, 32'(bsr)},
            '{`BSC_IR_IDCODE,   6'h20, TB_ID},
            '{`BSC_IR_USERCODE, 6'h20, TB_USER},
            '{`BSC_IR_CLAMP,    6'h01, 32'h0},
            '{`BSC_IR_HIGHZ,    6'h01, 32'h0},
            '{`BSC_IR_EXTEST,   6'h18, 32'(bsr)},
            '{`BSC_IR_REGRD,    6'h01, 32'h0},
            '{`BSC_IR_REGWR,    6'h01, 32'h0},
            '{4'hf,             6'h01, 32'h0}
        };
        repeat (6) @(posedge ref_clk);
        // the tck side only sees reset while tck runs
        ctl.tlr(4);
        @(posedge ref_clk) rst <= 1'b0;
        ctl.tlr(5);
        chk("tdo enable", 32'(tdo_oe), 32'h0);
        chk("interface off", 32'(host_if_off), 32'h0);
        chk("pad out", 32'(pad_out), 32'(core_out));
        foreach (rows[r]) begin
            ctl.scan(1'b1, 4, 32'(rows[r].code), got);
            chk("ir capture", got, 32'(`BSC_IR_CAPTURE));
            ctl.scan(1'b0, 32, PAT, got);
            want = (64'(PAT) << rows[r].len) | 64'(rows[r].cap);
            chk("dr out", got, want[31:0]);
            chk("shift enable", 32'({ctl.oe_ok, tdo_oe}), 32'h2);
            @(posedge ref_clk) core_out <= 12'(PAT >> r);
            repeat (20) @(posedge ref_clk);
            if (rows[r].code inside {`BSC_IR_EXTEST, `BSC_IR_CLAMP}) {po, pe} = {uo, ue};
            else if (rows[r].code == `BSC_IR_HIGHZ) {po, pe} = 24'h0;
            else {po, pe} = {core_out, core_oe};
            chk("pad out", 32'(pad_out), 32'(po));
            chk("pad enable", 32'(pad_oe), 32'(pe));
        end
        ctl.scan(1'b1, 4, 32'(`BSC_IR_IFCTL), got);
        ctl.scan(1'b0, 1, 32'h1, got);
        repeat (20) @(posedge ref_clk);
        chk("interface off", 32'(host_if_off), 32'h1);
        ctl.scan(1'b1, 4, 32'(`BSC_IR_REGRD), got);
        ctl.scan(1'b0, 15, 32'h002a, got);
        repeat (20) @(posedge ref_clk);
        chk("read address", 32'(reg_rd_addr), 32'h2a);
        repeat (4) ctl.step(1'b0, 1'b1);
        ctl.scan(1'b0, 15, 32'h002a, got);
        chk("read capture", got, {17'h0, regs_mem[7'h2a], 7'h2a});
        ctl.scan(1'b1, 4, 32'(`BSC_IR_REGWR), got);
        ctl.scan(1'b0, 15, 32'h2db1, got);
        repeat (20) @(posedge ref_clk);
        n0 = wr_cnt;
        ctl.scan(1'b0, 15, 32'h2db1, got);
        repeat (20) @(posedge ref_clk);
        chk("write count", 32'(wr_cnt - n0), 32'h1);
        chk("write target", {17'h0, wr_d, wr_a}, 32'h2db1);
        // abandon an instruction shift halfway, then force the reset state
        ctl.step(1'b1, 1'b1);
        ctl.step(1'b1, 1'b1);
        ctl.step(1'b0, 1'b1);
        ctl.step(1'b0, 1'b1);
        repeat (2) ctl.step(1'b0, 1'b0);
        ctl.tlr(5);
        repeat (20) @(posedge ref_clk);
        chk("interface off", 32'(host_if_off), 32'h0);
        ctl.stall = 1'b1;
        ctl.scan(1'b0, 32, PAT, got);
        ctl.stall = 1'b0;
        chk("id after reset", got, TB_ID);
        conclude();
    end
endmodule // bsc_tap_tb_top

`default_nettype wire
